// ==== design/motor_fault_supervisor.sv ====
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "motor_fault_supervisor_map.svh"

module motor_fault_supervisor #(
	parameter logic [23:0] TIMEOUT_INIT = 24'(`MFS_TIMEOUT_CYC),
	parameter logic [23:0] WDOG_INIT    = 24'(`MFS_WDOG_CYC)
) (
	input  wire logic                                 sys_clk,
	input  wire logic                                 rst,
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [7:0]                           paddr,
	input  wire logic [31:0]                          pwdata,
	output logic      [31:0]                          prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	input  wire logic [15:0]                          currentIn,
	input  wire logic [11:0]                          ctrlTempIn,
	input  wire logic [15:0]                          speedIn,
	input  wire logic [15:0]                          busVoltIn,
	input  wire logic [15:0]                          backEmfIn,
	input  wire motor_fault_supervisor_pkg::volt_t    voltReq,
	input  wire logic                                 msgValid,
	input  wire logic                                 heartbeat,
	output motor_fault_supervisor_pkg::volt_t         voltOut,
	output logic                                      switchEnable,
	output logic                                      brakeShort,
	output logic                                      coastMode,
	output logic                                      armed,
	output logic                                      derateActive,
	output logic                                      rebootReq
);
	// Scale a ramp: full at zero excess, falling by excess << sh
	function automatic logic [8:0] rampScale(input logic [15:0] excess, input logic [3:0] sh);
		logic [31:0] d;
		d = {16'h0000, excess} << sh;
		if (d >= 32'h0000_0100) begin
			return 9'h000;
		end
		return `MFS_SCALE_ONE - d[8:0];
	endfunction

	function automatic logic signed [15:0] applyScale(input logic signed [15:0] v,
		input logic [8:0] s);
		logic signed [25:0] p;
		p = v * $signed({1'b0, s});
		return p[23:8];
	endfunction

	function automatic logic [15:0] absV(input logic [15:0] v);
		return v[15] ? 16'(-v) : v;
	endfunction

	// Synchronised sensor samples; stage one feeds stage two only
	logic [15:0] curS1, curS2, spdS1, spdS2, busS1, busS2, emfS1, emfS2;
	logic [11:0] tmpS1, tmpS2;
	always_ff @(posedge sys_clk) begin
		curS1 <= currentIn;
		curS2 <= curS1;
		tmpS1 <= ctrlTempIn;
		tmpS2 <= tmpS1;
		spdS1 <= speedIn;
		spdS2 <= spdS1;
		busS1 <= busVoltIn;
		busS2 <= busS1;
		emfS1 <= backEmfIn;
		emfS2 <= emfS1;
	end

	// Configuration registers
	logic        ocLatchMode, otLatchMode;
	logic [15:0] curLimit, headroom, speedMax, speedBrake, regenMax;
	logic [11:0] derateTemp, tripTemp;
	logic [3:0]  derateShift, speedShift;
	logic [7:0]  coilGain;
	logic [23:0] timeoutLimit, wdogLimit;
	logic        armReg, ocFlag, otFlag, wdogFlag, cmdLost;
	logic [11:0] coilEst;
	motor_fault_supervisor_pkg::supPhase_e phase;

	logic wrAcc, rdSetup, errClr;
	assign wrAcc   = psel & penable & pwrite & pready;
	assign rdSetup = psel & ~penable;
	assign errClr  = wrAcc & (paddr == `MFS_OFS_ERR_CLEAR);

	// Live fault conditions
	logic ocNow, otNow, overSpeed, extremeSpeed, regenHigh;
	logic [15:0] spdAbs;
	assign spdAbs       = absV(spdS2);
	assign ocNow        = curS2 > curLimit;
	assign otNow        = (tmpS2 >= tripTemp) | (coilEst >= tripTemp);
	assign overSpeed    = spdAbs > speedMax;
	assign extremeSpeed = spdAbs > speedBrake;
	assign regenHigh    = busS2 > regenMax;

	// Register writes; reboot restores the self-clearing defaults
	always_ff @(posedge sys_clk) begin
		if (rst || phase == motor_fault_supervisor_pkg::SUP_REBOOT) begin
			ocLatchMode  <= 1'b0;
			otLatchMode  <= 1'b0;
			curLimit     <= `MFS_RST_CUR_LIMIT;
			headroom     <= `MFS_RST_HEADROOM;
			derateTemp   <= `MFS_RST_DERATE_T;
			tripTemp     <= `MFS_RST_TRIP_T;
			derateShift  <= `MFS_RST_DERATE_SH;
			speedShift   <= `MFS_RST_SPEED_SH;
			coilGain     <= `MFS_RST_COIL_GAIN;
			speedMax     <= `MFS_RST_SPEED_MAX;
			speedBrake   <= `MFS_RST_SPEED_BRAKE;
			regenMax     <= `MFS_RST_REGEN_MAX;
			timeoutLimit <= TIMEOUT_INIT;
			wdogLimit    <= WDOG_INIT;
		end else if (wrAcc) begin
			case (paddr)
				`MFS_OFS_CTRL: begin
					ocLatchMode <= pwdata[`MFS_CTRL_OC_LATCH];
					otLatchMode <= pwdata[`MFS_CTRL_OT_LATCH];
				end
				`MFS_OFS_CUR_LIMIT:   curLimit <= pwdata[15:0];
				`MFS_OFS_HEADROOM:    headroom <= pwdata[15:0];
				`MFS_OFS_TEMP_CFG: begin
					derateTemp <= pwdata[11:0];
					tripTemp   <= pwdata[27:16];
				end
				`MFS_OFS_SHAPE: begin
					derateShift <= pwdata[3:0];
					speedShift  <= pwdata[7:4];
					coilGain    <= pwdata[15:8];
				end
				`MFS_OFS_SPEED_MAX:   speedMax <= pwdata[15:0];
				`MFS_OFS_SPEED_BRAKE: speedBrake <= pwdata[15:0];
				`MFS_OFS_REGEN_MAX:   regenMax <= pwdata[15:0];
				`MFS_OFS_TIMEOUT:     timeoutLimit <= pwdata[23:0];
				`MFS_OFS_WDOG_LIMIT:  wdogLimit <= pwdata[23:0];
				default: begin
				end
			endcase
		end
	end

	// Arming; a reboot drops it so the host must arm again
	always_ff @(posedge sys_clk) begin
		if (rst || phase == motor_fault_supervisor_pkg::SUP_REBOOT) begin
			armReg <= 1'b0;
		end else if (wrAcc && paddr == `MFS_OFS_CTRL) begin
			armReg <= pwdata[`MFS_CTRL_ARM];
		end
	end

	// Sticky trip flags; a trip in the clearing cycle wins
	always_ff @(posedge sys_clk) begin
		if (rst || phase == motor_fault_supervisor_pkg::SUP_REBOOT) begin
			ocFlag <= 1'b0;
			otFlag <= 1'b0;
		end else begin
			if (ocNow) begin
				ocFlag <= 1'b1;
			end else if (errClr && pwdata[`MFS_ST_OC_FLAG]) begin
				ocFlag <= 1'b0;
			end
			if (otNow) begin
				otFlag <= 1'b1;
			end else if (errClr && pwdata[`MFS_ST_OT_FLAG]) begin
				otFlag <= 1'b0;
			end
		end
	end

	// First-order coil heating model, relaxes toward a loss target
	logic signed [16:0] coilTarget, coilStep;
	logic [23:0] heatTerm;
	always_comb begin
		heatTerm   = curS2 * coilGain;
		coilTarget = 17'({5'h00, tmpS2}) + 17'({1'b0, heatTerm[23:8]});
		if (coilTarget > 17'sh00fff) begin
			coilTarget = 17'sh00fff;
		end
		// Signed difference so a cooling coil steps the estimate down
		coilStep = (coilTarget - $signed({5'h00, coilEst})) >>> 4;
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			coilEst <= 12'h000;
		end else begin
			coilEst <= 12'(17'({5'h00, coilEst}) + coilStep);
		end
	end

	// Command timeout; counter reloads on every valid message
	logic [23:0] cmdCount;
	always_ff @(posedge sys_clk) begin
		if (rst || phase == motor_fault_supervisor_pkg::SUP_REBOOT) begin
			cmdCount <= 24'h000000;
			cmdLost  <= 1'b0;
		end else if (msgValid) begin
			cmdCount <= 24'h000000;
			cmdLost  <= 1'b0;
		end else if (cmdCount >= timeoutLimit) begin
			cmdLost <= 1'b1;
		end else begin
			cmdCount <= cmdCount + 24'h000001;
		end
	end

	// Watchdog on the controller heartbeat; expiry costs one reboot cycle
	logic [23:0] wdogCount;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wdogCount <= 24'h000000;
			phase     <= motor_fault_supervisor_pkg::SUP_RUN;
			wdogFlag  <= 1'b0;
		end else begin
			case (phase)
				motor_fault_supervisor_pkg::SUP_RUN: begin
					if (heartbeat) begin
						wdogCount <= 24'h000000;
					end else if (wdogCount >= wdogLimit) begin
						phase    <= motor_fault_supervisor_pkg::SUP_REBOOT;
						wdogFlag <= 1'b1;
					end else begin
						wdogCount <= wdogCount + 24'h000001;
					end
					if (errClr && pwdata[`MFS_ST_WDOG]) begin
						wdogFlag <= 1'b0;
					end
				end
				motor_fault_supervisor_pkg::SUP_REBOOT: begin
					wdogCount <= 24'h000000;
					phase     <= motor_fault_supervisor_pkg::SUP_RUN;
				end
				default: phase <= motor_fault_supervisor_pkg::SUP_RUN;
			endcase
		end
	end

	// Voltage shaping: derate, overspeed, predictive clamp, regen limit
	logic [8:0]  ctrlScale, coilScale, thermScale, spdScale;
	logic        derating, gateOff, ocHold, otHold;
	logic signed [15:0] vScaled, vClamped, vFinal;
	logic signed [16:0] vLo, vHi, emfX;
	always_comb begin
		ctrlScale  = (tmpS2 > derateTemp) ?
			rampScale(16'(tmpS2 - derateTemp), derateShift) : `MFS_SCALE_ONE;
		coilScale  = (coilEst > derateTemp) ?
			rampScale(16'(coilEst - derateTemp), derateShift) : `MFS_SCALE_ONE;
		thermScale = (ctrlScale < coilScale) ? ctrlScale : coilScale;
		derating   = thermScale != `MFS_SCALE_ONE;
		spdScale   = overSpeed ? rampScale(spdAbs - speedMax, speedShift) : `MFS_SCALE_ONE;
		vScaled    = applyScale(applyScale(voltReq, thermScale), spdScale);
		emfX       = 17'($signed(emfS2));
		vLo        = emfX - $signed({1'b0, headroom});
		vHi        = emfX + $signed({1'b0, headroom});
		// Clamp around back-EMF bounds the current the winding can draw
		if (17'(vScaled) < vLo) begin
			vClamped = (vLo < -17'sd32768) ? -16'sd32768 : 16'(vLo);
		end else if (17'(vScaled) > vHi) begin
			vClamped = (vHi > 17'sd32767) ? 16'sd32767 : 16'(vHi);
		end else begin
			vClamped = vScaled;
		end
		// Matching back-EMF stops net generation into the bus
		vFinal  = regenHigh ? $signed(emfS2) : vClamped;
		ocHold  = ocLatchMode & ocFlag;
		otHold  = otLatchMode & otFlag;
		gateOff = ocNow | ocHold | otNow | otHold;
	end

	// Power stage outputs; gating beats every request in the same edge
	always_ff @(posedge sys_clk) begin
		if (rst || phase == motor_fault_supervisor_pkg::SUP_REBOOT) begin
			voltOut      <= 16'sh0000;
			switchEnable <= 1'b0;
			brakeShort   <= 1'b0;
			coastMode    <= 1'b1;
			armed        <= 1'b0;
			derateActive <= 1'b0;
		end else begin
			derateActive <= derating;
			armed        <= armReg & ~cmdLost;
			if (gateOff) begin
				voltOut      <= 16'sh0000;
				switchEnable <= 1'b0;
				brakeShort   <= 1'b0;
				coastMode    <= 1'b0;
			end else if (extremeSpeed) begin
				voltOut      <= 16'sh0000;
				switchEnable <= 1'b1;
				brakeShort   <= 1'b1;
				coastMode    <= 1'b0;
			end else if (cmdLost || !armReg) begin
				voltOut      <= 16'sh0000;
				switchEnable <= 1'b0;
				brakeShort   <= 1'b0;
				coastMode    <= 1'b1;
			end else begin
				voltOut      <= vFinal;
				switchEnable <= 1'b1;
				brakeShort   <= 1'b0;
				coastMode    <= 1'b0;
			end
		end
	end

	// Reboot strobe to the rest of the controller
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rebootReq <= 1'b0;
		end else begin
			rebootReq <= phase == motor_fault_supervisor_pkg::SUP_REBOOT;
		end
	end

	// APB read data prepared in setup; zero wait states
	logic [31:0] rdMux;
	logic        rdErr;
	always_comb begin
		rdMux = 32'h0000_0000;
		rdErr = 1'b0;
		case (paddr)
			`MFS_OFS_CTRL:        rdMux = {29'h0, armReg, otLatchMode, ocLatchMode};
			`MFS_OFS_CUR_LIMIT:   rdMux = {16'h0000, curLimit};
			`MFS_OFS_HEADROOM:    rdMux = {16'h0000, headroom};
			`MFS_OFS_TEMP_CFG:    rdMux = {4'h0, tripTemp, 4'h0, derateTemp};
			`MFS_OFS_SHAPE:       rdMux = {16'h0000, coilGain, speedShift, derateShift};
			`MFS_OFS_SPEED_MAX:   rdMux = {16'h0000, speedMax};
			`MFS_OFS_SPEED_BRAKE: rdMux = {16'h0000, speedBrake};
			`MFS_OFS_REGEN_MAX:   rdMux = {16'h0000, regenMax};
			`MFS_OFS_TIMEOUT:     rdMux = {8'h00, timeoutLimit};
			`MFS_OFS_WDOG_LIMIT:  rdMux = {8'h00, wdogLimit};
			`MFS_OFS_ERR_CLEAR:   rdMux = 32'h0000_0000;
			`MFS_OFS_STATUS:      rdMux = {22'h0, armReg & ~cmdLost, wdogFlag, regenHigh,
				extremeSpeed, cmdLost, derating, otFlag, ocFlag, otNow, ocNow};
			default:              rdErr = 1'b1;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= rdSetup;
			pslverr <= rdSetup & rdErr;
			if (rdSetup && !pwrite) begin
				prdata <= rdMux;
			end
		end
	end

	// Checks beside the logic
	property p_oc_gate;
		@(posedge sys_clk) disable iff (rst) ocNow |=> !switchEnable && voltOut == 16'sh0000;
	endproperty
	a_oc_gate: assert property (p_oc_gate) else $error("over-current left switches on");

	property p_ot_gate;
		@(posedge sys_clk) disable iff (rst) otNow |=> !switchEnable;
	endproperty
	a_ot_gate: assert property (p_ot_gate) else $error("over-temperature left switches on");

	property p_oc_latch_hold;
		@(posedge sys_clk) disable iff (rst)
			(ocLatchMode && ocFlag && !errClr && phase == motor_fault_supervisor_pkg::SUP_RUN
			&& $past(ocLatchMode)) |=> !switchEnable;
	endproperty
	a_oc_latch_hold: assert property (p_oc_latch_hold) else $error("latched trip released");

	property p_oc_self_clear;
		@(posedge sys_clk) disable iff (rst)
			(!ocLatchMode && !otLatchMode && !ocNow && !otNow && !extremeSpeed && armReg
			&& !cmdLost && !msgValid && phase == motor_fault_supervisor_pkg::SUP_RUN
			&& !wrAcc) |=> switchEnable;
	endproperty
	a_oc_self_clear: assert property (p_oc_self_clear) else $error("self-clearing trip held");

	property p_default_mode;
		@(posedge sys_clk) $past(rst) |-> !ocLatchMode && !otLatchMode;
	endproperty
	a_default_mode: assert property (p_default_mode) else $error("latching after reset");

	property p_brake;
		@(posedge sys_clk) disable iff (rst)
			(extremeSpeed && !gateOff && phase == motor_fault_supervisor_pkg::SUP_RUN)
			|=> brakeShort && switchEnable;
	endproperty
	a_brake: assert property (p_brake) else $error("no phase short at extreme speed");

	property p_timeout;
		@(posedge sys_clk) disable iff (rst)
			(cmdCount >= timeoutLimit && !msgValid && !gateOff && !extremeSpeed
			&& phase == motor_fault_supervisor_pkg::SUP_RUN) |=> ##1 coastMode && !armed;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not coast");

	property p_msg_reload;
		@(posedge sys_clk) disable iff (rst) msgValid |=> cmdCount == 24'h000000 && !cmdLost;
	endproperty
	a_msg_reload: assert property (p_msg_reload) else $error("message did not reload");

	property p_reboot;
		@(posedge sys_clk) disable iff (rst)
			$rose(wdogFlag) |-> ##1 rebootReq ##1 !rebootReq && !armReg;
	endproperty
	a_reboot: assert property (p_reboot) else $error("watchdog reboot malformed");

	property p_clamp;
		@(posedge sys_clk) disable iff (rst)
			!regenHigh |-> 17'(vFinal) >= vLo && 17'(vFinal) <= vHi;
	endproperty
	a_clamp: assert property (p_clamp) else $error("voltage outside current bound");
endmodule

// ==== design/motor_fault_supervisor_map.svh ====
`ifndef MOTOR_FAULT_SUPERVISOR_MAP_SVH
`define MOTOR_FAULT_SUPERVISOR_MAP_SVH

// Clock and long timing figures
`define MFS_CLK_NS          8
`define MFS_TIMEOUT_MS      100
`define MFS_WDOG_MS         50
`define MFS_TIMEOUT_CYC     ((`MFS_TIMEOUT_MS * 1000000) / `MFS_CLK_NS)
`define MFS_WDOG_CYC        ((`MFS_WDOG_MS * 1000000) / `MFS_CLK_NS)

// Register byte offsets
`define MFS_OFS_CTRL        8'h00
`define MFS_OFS_CUR_LIMIT   8'h04
`define MFS_OFS_HEADROOM    8'h08
`define MFS_OFS_TEMP_CFG    8'h0c
`define MFS_OFS_SHAPE       8'h10
`define MFS_OFS_SPEED_MAX   8'h14
`define MFS_OFS_SPEED_BRAKE 8'h18
`define MFS_OFS_REGEN_MAX   8'h1c
`define MFS_OFS_TIMEOUT     8'h20
`define MFS_OFS_STATUS      8'h24
`define MFS_OFS_ERR_CLEAR   8'h28
`define MFS_OFS_WDOG_LIMIT  8'h2c

// Field positions
`define MFS_CTRL_OC_LATCH   0
`define MFS_CTRL_OT_LATCH   1
`define MFS_CTRL_ARM        2
`define MFS_ST_OC_NOW       0
`define MFS_ST_OT_NOW       1
`define MFS_ST_OC_FLAG      2
`define MFS_ST_OT_FLAG      3
`define MFS_ST_DERATE       4
`define MFS_ST_CMD_LOST     5
`define MFS_ST_BRAKE        6
`define MFS_ST_REGEN        7
`define MFS_ST_WDOG         8
`define MFS_ST_ARMED        9

// Reset values
`define MFS_RST_CTRL        32'h0000_0000
`define MFS_RST_CUR_LIMIT   16'h4000
`define MFS_RST_HEADROOM    16'h1000
`define MFS_RST_DERATE_T    12'h500
`define MFS_RST_TRIP_T      12'h600
`define MFS_RST_DERATE_SH   4'h2
`define MFS_RST_SPEED_SH    4'h2
`define MFS_RST_COIL_GAIN   8'h10
`define MFS_RST_SPEED_MAX   16'h4000
`define MFS_RST_SPEED_BRAKE 16'h6000
`define MFS_RST_REGEN_MAX   16'h7000
`define MFS_SCALE_ONE       9'h100

`endif

// ==== design/motor_fault_supervisor_pkg.sv ====
package motor_fault_supervisor_pkg;
	// Supervisor phase: a watchdog reboot takes one cycle of its own
	typedef enum logic [0:0] {
		SUP_RUN,
		SUP_REBOOT
	} supPhase_e;
	typedef logic signed [15:0] volt_t;
endpackage

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
module host_model (
	input  wire logic        sys_clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             msgValid,
	output logic             heartbeat
);
	logic       msgOn;
	logic       beatOn;
	logic [5:0] tick;

	// Idle bus, no messages until the bench enables them; heartbeat runs from the start
	initial begin
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0000_0000;
		msgOn     = 1'b0;
		beatOn    = 1'b1;
		tick      = 6'h00;
		msgValid  = 1'b0;
		heartbeat = 1'b0;
	end

	// Paced pulses; period 64 stays well inside both timers
	always @(posedge sys_clk) begin
		tick      <= tick + 6'h01;
		msgValid  <= msgOn && (tick == 6'h00);
		heartbeat <= beatOn && (tick == 6'h20);
	end

	// One transfer; request held until pready is sampled high
	task automatic apbXfer(
		input  logic [7:0]  a,
		input  logic        w,
		input  logic [31:0] d,
		output logic [31:0] r,
		output logic        e
	);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Gap edge so a following call never reassigns psel in one step
		@(posedge sys_clk);
	endtask
endmodule

// ==== tb/motor_fault_supervisor_bench.sv ====
`timescale 1ns/1ps
`include "motor_fault_supervisor_map.svh"
module motor_fault_supervisor_bench;
	`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
		$display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
	localparam int TMO = 200;
	localparam int WDG = 400;
	typedef struct packed {
		logic [15:0] cur;
		logic [11:0] tmp;
		logic [15:0] spd;
		logic [15:0] bus;
		logic [15:0] emf;
		logic [15:0] req;
		logic        sw;
		logic        brk;
		logic        chk;
		logic [15:0] v;
		logic        drt;
	} row_s;
	logic                              sys_clk, rst, psel, penable, pwrite;
	logic [7:0]                        paddr;
	logic [31:0]                       pwdata, prdata, rdVal;
	logic                              pready, pslverr, msgValid, heartbeat, rdErr;
	logic [15:0]                       currentIn, speedIn, busVoltIn, backEmfIn;
	logic [11:0]                       ctrlTempIn;
	motor_fault_supervisor_pkg::volt_t voltReq, voltOut;
	logic                              switchEnable, brakeShort, coastMode, armed;
	logic                              derateActive, rebootReq;
	int                                err_count, checks_done, reboots;
	// Self-clearing mode, armed, messages flowing
	row_s rows [13] = '{
		'{16'h0000, 12'h000, 16'h0000, 16'h0000, 16'h0000, 16'h0100, 1, 0, 1, 16'h0100, 0},
		'{16'h4001, 12'h000, 16'h0000, 16'h0000, 16'h0000, 16'h0100, 0, 0, 1, 16'h0000, 0},
		'{16'h4000, 12'h000, 16'h0000, 16'h0000, 16'h0000, 16'h0100, 1, 0, 1, 16'h0100, 0},
		'{16'h0000, 12'h000, 16'h0000, 16'h0000, 16'h0000, 16'h2000, 1, 0, 1, 16'h1000, 0},
		'{16'h0000, 12'h000, 16'h0000, 16'h0000, 16'h0000, 16'he000, 1, 0, 1, 16'hf000, 0},
		'{16'h0000, 12'h000, 16'h4010, 16'h0000, 16'h0000, 16'h0100, 1, 0, 1, 16'h00c0, 0},
		'{16'h0000, 12'h000, 16'hbff0, 16'h0000, 16'h0000, 16'h0100, 1, 0, 1, 16'h00c0, 0},
		'{16'h0000, 12'h000, 16'h6001, 16'h0000, 16'h0000, 16'h0100, 1, 1, 0, 16'h0000, 0},
		'{16'h0000, 12'h000, 16'h0000, 16'h7001, 16'h0050, 16'h0100, 1, 0, 1, 16'h0050, 0},
		'{16'h0000, 12'h510, 16'h0000, 16'h0000, 16'h0000, 16'h0100, 1, 0, 1, 16'h00c0, 1},
		'{16'h0000, 12'h000, 16'h0000, 16'h0000, 16'h0000, 16'h0100, 1, 0, 1, 16'h0100, 0},
		'{16'h0000, 12'h600, 16'h0000, 16'h0000, 16'h0000, 16'h0100, 0, 0, 0, 16'h0000, 0},
		'{16'h0000, 12'h000, 16'h0000, 16'h0000, 16'h0000, 16'h0100, 1, 0, 0, 16'h0000, 0}
	};

	motor_fault_supervisor #(
		.TIMEOUT_INIT (24'(TMO)),
		.WDOG_INIT    (24'(WDG))
	) dut (
		.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .currentIn(currentIn), .ctrlTempIn(ctrlTempIn),
		.speedIn(speedIn), .busVoltIn(busVoltIn), .backEmfIn(backEmfIn),
		.voltReq(voltReq), .msgValid(msgValid), .heartbeat(heartbeat),
		.voltOut(voltOut), .switchEnable(switchEnable), .brakeShort(brakeShort),
		.coastMode(coastMode), .armed(armed), .derateActive(derateActive),
		.rebootReq(rebootReq)
	);

	host_model host (
		.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .msgValid(msgValid), .heartbeat(heartbeat)
	);

	// Clock, 8 ns period
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Counts reboot pulses seen at the edge
	always @(posedge sys_clk) begin
		if (rebootReq === 1'b1) reboots <= reboots + 1;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.apbXfer(a, 1'b1, d, rdVal, rdErr);
	endtask

	task automatic rd(input logic [7:0] a);
		host.apbXfer(a, 1'b0, 32'h0000_0000, rdVal, rdErr);
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Hang guard, far beyond the planned run
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		test_done();
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		{currentIn, speedIn, busVoltIn, backEmfIn, voltReq} = '0;
		ctrlTempIn = 12'h000;
		err_count = 0;
		checks_done = 0;
		reboots = 0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		wr(`MFS_OFS_CTRL, 32'h0000_0004);
		host.msgOn <= 1'b1;
		repeat (80) @(posedge sys_clk);
		for (int i = 0; i < 13; i++) begin
			currentIn  <= rows[i].cur;
			ctrlTempIn <= rows[i].tmp;
			speedIn    <= rows[i].spd;
			busVoltIn  <= rows[i].bus;
			backEmfIn  <= rows[i].emf;
			voltReq    <= rows[i].req;
			repeat (8) @(posedge sys_clk);
			`CHK(switchEnable, rows[i].sw)
			`CHK(brakeShort, rows[i].brk)
			if (rows[i].chk) begin
				`CHK(voltOut, rows[i].v)
				`CHK(derateActive, rows[i].drt)
			end
			$display("row %0d done", i);
		end
		// Latched over-current stays off after the current drops
		wr(`MFS_OFS_CTRL, 32'h0000_0005);
		currentIn <= 16'h4001;
		repeat (8) @(posedge sys_clk);
		currentIn <= 16'h0000;
		repeat (8) @(posedge sys_clk);
		`CHK(switchEnable, 1'b0)
		rd(`MFS_OFS_STATUS);
		`CHK(rdVal[`MFS_ST_OC_FLAG], 1'b1)
		wr(`MFS_OFS_ERR_CLEAR, 32'h0000_0004);
		repeat (8) @(posedge sys_clk);
		`CHK(switchEnable, 1'b1)
		wr(`MFS_OFS_CTRL, 32'h0000_0004);
		$display("latch test done");
		// Messages stop: coast after the timeout, back on the next one
		`CHK(armed, 1'b1)
		host.msgOn <= 1'b0;
		repeat (TMO + 10) @(posedge sys_clk);
		`CHK(coastMode, 1'b1)
		`CHK(armed, 1'b0)
		host.msgOn <= 1'b1;
		repeat (70) @(posedge sys_clk);
		`CHK(coastMode, 1'b0)
		`CHK(armed, 1'b1)
		$display("timeout test done");
		// Heartbeat stops: one reboot, arm lost until rewritten
		host.beatOn <= 1'b0;
		repeat (WDG + 80) @(posedge sys_clk);
		`CHK(reboots, 1)
		`CHK(armed, 1'b0)
		host.beatOn <= 1'b1;
		rd(`MFS_OFS_CTRL);
		`CHK(rdVal, 32'h0000_0000)
		wr(`MFS_OFS_CTRL, 32'h0000_0004);
		repeat (70) @(posedge sys_clk);
		`CHK(armed, 1'b1)
		$display("watchdog test done");
		// Reset in mid-run, then defaults and an unmapped slot
		rst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		`CHK(switchEnable, 1'b0)
		`CHK(coastMode, 1'b1)
		`CHK(voltOut, 16'h0000)
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(`MFS_OFS_CTRL);
		`CHK(rdVal, 32'h0000_0000)
		rd(`MFS_OFS_TEMP_CFG);
		`CHK(rdVal, 32'h0600_0500)
		rd(8'h30);
		`CHK(rdErr, 1'b1)
		`CHK(rdVal, 32'h0000_0000)
		$display("reset test done");
		test_done();
	end
endmodule
